// file: clgo_pkg.sv
// shared constants for the clock gating override block
package clgo_pkg;

  // bus widths
  localparam int unsigned CLGO_DW         = 32;     // apb data width
  localparam int unsigned CLGO_AW         = 12;     // apb byte address width
  localparam int unsigned CLGO_NUM_FLAGS  = 12;     // override flags, bits 11 down to 0
  localparam int unsigned CLGO_MAX_CPLX   = 8;      // complex bits 11 down to 4

  // register byte offsets
  localparam logic [CLGO_AW-1:0] CLGO_OFS_STATUS = 12'ha00;
  localparam logic [CLGO_AW-1:0] CLGO_OFS_SET    = 12'ha04;
  localparam logic [CLGO_AW-1:0] CLGO_OFS_CLEAR  = 12'ha08;
  localparam logic [1:0]         CLGO_ALIGN_OK   = 2'h0;    // word aligned low bits

  // bit positions of the override flags
  localparam int unsigned CLGO_BIT_PROC    = 0;     // processor clock, direct mode only
  localparam int unsigned CLGO_BIT_POWER   = 1;     // cluster power policy clock
  localparam int unsigned CLGO_BIT_IRQ     = 2;     // cluster irq controller clock
  localparam int unsigned CLGO_BIT_PERIPH  = 3;     // cluster peripheral clock
  localparam int unsigned CLGO_BIT_CPLX_LO = 4;     // first per complex bit
  localparam int unsigned CLGO_BIT_CPLX_HI = 11;    // last per complex bit

  // reset values
  localparam logic [CLGO_NUM_FLAGS-1:0] CLGO_FLAG_RESET  = 12'h000;      // gating enabled
  localparam logic [CLGO_DW-1:0]        CLGO_RDATA_RESET = 32'h0000_0000;
  localparam logic [CLGO_DW-CLGO_NUM_FLAGS-1:0] CLGO_RSVD_ZERO = 20'h0_0000;

  // register selected by an address
  typedef enum logic [1:0] {
    CLGO_REG_NONE,
    CLGO_REG_STATUS,
    CLGO_REG_SET,
    CLGO_REG_CLEAR
  } clgo_reg_t;

endpackage

// file: clgo_reg_if.sv
`timescale 1ns/100ps

// links the bus slave, the decode in the top and the flag bank
interface clgo_reg_if;
  import clgo_pkg::*;

  logic                      acc_wr;     // write completes this edge
  logic                      acc_rd;     // read data is captured this edge
  logic [CLGO_AW-1:0]        acc_addr;   // byte address of the transfer
  logic [CLGO_DW-1:0]        acc_wdata;  // write data of the transfer
  logic [CLGO_DW-1:0]        acc_rdata;  // read word for the address
  logic                      acc_err;    // address is not mapped
  logic [CLGO_NUM_FLAGS-1:0] set_bits;   // one cycle set strobes
  logic [CLGO_NUM_FLAGS-1:0] clr_bits;   // one cycle clear strobes
  logic [CLGO_NUM_FLAGS-1:0] flags;      // override flag state

  modport bus  (output acc_wr, acc_rd, acc_addr, acc_wdata, input acc_rdata, acc_err);
  modport core (input acc_wr, acc_rd, acc_addr, acc_wdata, flags,
                output acc_rdata, acc_err, set_bits, clr_bits);
  modport bank (input set_bits, clr_bits, output flags);
endinterface

// file: clgo_apb_slave.sv
`timescale 1ns/100ps

// apb handshake: one wait state, registered answer
module clgo_apb_slave (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb request
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [clgo_pkg::CLGO_AW-1:0]  paddr,
  input  wire logic [clgo_pkg::CLGO_DW-1:0]  pwdata,
  // apb answer
  output logic                               pready,
  output logic [clgo_pkg::CLGO_DW-1:0]       prdata,
  output logic                               pslverr,
  // towards decode
  clgo_reg_if.bus                            rif
);
  import clgo_pkg::*;

  logic capture;   // first access cycle, answer is prepared here

  // the answer is computed one cycle early so every answer bit is a flop
  assign capture       = psel & penable & ~pready;
  assign rif.acc_rd    = capture & ~pwrite;
  // a write lands only on the edge where the master sees pready
  assign rif.acc_wr    = psel & penable & pready & pwrite;
  assign rif.acc_addr  = paddr;
  assign rif.acc_wdata = pwdata;

  // ready rises after one wait cycle and drops after the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= capture;
    end
  end

  // read data and error are loaded with ready, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= CLGO_RDATA_RESET;
      pslverr <= 1'b0;
    end else begin
      prdata  <= rif.acc_rd ? rif.acc_rdata : CLGO_RDATA_RESET;
      pslverr <= capture & rif.acc_err;
    end
  end
endmodule

// file: clgo_flag_bank.sv
`timescale 1ns/100ps

// one override flag per clock
module clgo_flag_bank (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // strobes in, flags out
  clgo_reg_if.bank  rif
);
  import clgo_pkg::*;

  // set and clear come from different registers and cannot meet,
  // but set is still given priority so a hazard never drops a force
  // one flag per clock
  for (genvar i = 0; i < CLGO_NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rif.flags[i] <= CLGO_FLAG_RESET[i];
      end else if (rif.set_bits[i]) begin
        rif.flags[i] <= 1'b1;
      end else if (rif.clr_bits[i]) begin
        rif.flags[i] <= 1'b0;
      end
    end
  end
endmodule

// file: clgo_top.sv
`timescale 1ns/100ps

// Function
// - status register shows gating state per clock
// - status one means gating disabled
// - set register one disables gating
// - clear register one re-enables gating
// - zero bits written change nothing
// - set and clear share status bit map
// - unimplemented clock bits are reserved everywhere
// - bits 3..0 periph, irq, power, processor
// - multi complex mode adds complex bits 11..4
// - unused bits read zero, writes ignored
module clgo_top #(
  parameter bit          multi_complex_mode  = 1'b0,   // per complex bits instead of bit 0
  parameter int unsigned complex_count       = 8,      // implemented complexes, up to 8
  parameter logic [3:0]  cluster_gating_impl = 4'hf    // cluster clocks with dynamic gating
) (
  // clock and reset
  input  wire logic                                          pclk,
  input  wire logic                                          presetn,
  // apb request
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [clgo_pkg::CLGO_AW-1:0]                  paddr,
  input  wire logic [clgo_pkg::CLGO_DW-1:0]                  pwdata,
  // apb answer
  output logic                                               pready,
  output logic [clgo_pkg::CLGO_DW-1:0]                       prdata,
  output logic                                               pslverr,
  // gating overrides, high disables dynamic gating
  output logic                                               peripheral_clock_override,
  output logic                                               irq_ctrl_clock_override,
  output logic                                               power_policy_clock_override,
  output logic                                               processor_clock_override,
  output logic [clgo_pkg::CLGO_MAX_CPLX-1:0]                 per_complex_clock_override
);
  import clgo_pkg::*;

  // bits that exist in this configuration
  // the mask is worked out once at elaboration; a clock without dynamic
  // gating keeps its flag at reset, so its bit reads zero and ignores writes
  // complex bits past the implemented count are treated the same way
  function automatic logic [CLGO_NUM_FLAGS-1:0] build_mask(
    input bit          mc,
    input int unsigned ncplx,
    input logic [3:0]  impl
  );
    logic [CLGO_NUM_FLAGS-1:0] m;
    m = CLGO_FLAG_RESET;
    m[CLGO_BIT_PERIPH] = impl[CLGO_BIT_PERIPH];
    m[CLGO_BIT_IRQ]    = impl[CLGO_BIT_IRQ];
    m[CLGO_BIT_POWER]  = impl[CLGO_BIT_POWER];
    // processor bit only in direct mode
    if (!mc) begin
      m[CLGO_BIT_PROC] = impl[CLGO_BIT_PROC];
    end else begin
      for (int i = 0; i < CLGO_MAX_CPLX; i++) begin
        if (i < ncplx) begin
          m[CLGO_BIT_CPLX_LO + i] = 1'b1;
        end
      end
    end
    return m;
  endfunction

  // register selected by a byte address
  // only whole aligned words are mapped; a partial address could otherwise
  // alias a neighbour and let a stray write set or clear the wrong clocks
  function automatic clgo_reg_t decode(input logic [CLGO_AW-1:0] a);
    clgo_reg_t r;
    r = CLGO_REG_NONE;
    // misaligned addresses map nowhere
    if (a[1:0] == CLGO_ALIGN_OK) begin
      if (a == CLGO_OFS_STATUS) begin
        r = CLGO_REG_STATUS;
      end else if (a == CLGO_OFS_SET) begin
        r = CLGO_REG_SET;
      end else if (a == CLGO_OFS_CLEAR) begin
        r = CLGO_REG_CLEAR;
      end
    end
    return r;
  endfunction

  // fixed per build; only these bits can ever hold a one
  localparam logic [CLGO_NUM_FLAGS-1:0] VALID_MASK =
    build_mask(multi_complex_mode, complex_count, cluster_gating_impl);

  clgo_reg_if rif ();                    // internal links

  clgo_reg_t                 acc_reg;    // register hit by the transfer
  logic [CLGO_NUM_FLAGS-1:0] wr_bits;    // write data limited to live bits
  logic [CLGO_DW-1:0]        rd_word;    // read value for the address

  // apb slave, answers after one wait cycle
  // the wait state lets every answer bit leave a flop; the cost is one
  // extra cycle per transfer, which software on this block never notices
  clgo_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .rif     (rif.bus)
  );

  // override flags
  // kept in their own module so the override outputs stay plain flops
  clgo_flag_bank u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif.bank)
  );

  // address decode shared by read and write paths
  assign acc_reg     = decode(rif.acc_addr);
  assign rif.acc_err = (acc_reg == CLGO_REG_NONE);

  // writes ignored above
  // reserved bits are dropped here, so their flags stay at reset
  // unimplemented bits dropped
  assign wr_bits = rif.acc_wdata[CLGO_NUM_FLAGS-1:0] & VALID_MASK;

  // set strobes, only ones in the data act
  // ones disable gating
  assign rif.set_bits = (rif.acc_wr && acc_reg == CLGO_REG_SET) ? wr_bits : CLGO_FLAG_RESET;

  // clear strobes, same bit map as the set register
  // ones re-enable gating
  assign rif.clr_bits = (rif.acc_wr && acc_reg == CLGO_REG_CLEAR) ? wr_bits : CLGO_FLAG_RESET;

  // read mux; set and clear are write only and read zero
  always_comb begin
    rd_word = CLGO_RDATA_RESET;
    // each code of the enum has its own arm, so no default is needed
    unique case (acc_reg)
      CLGO_REG_STATUS: begin
        rd_word = {CLGO_RSVD_ZERO, rif.flags};
      end
      CLGO_REG_SET: begin
        rd_word = CLGO_RDATA_RESET;
      end
      CLGO_REG_CLEAR: begin
        rd_word = CLGO_RDATA_RESET;
      end
      CLGO_REG_NONE: begin
        rd_word = CLGO_RDATA_RESET;
      end
    endcase
  end
  assign rif.acc_rdata = rd_word;

  // override outputs are the flag flops themselves
  // so no extra stage is needed and the pins move with the status bits
  // named bit positions
  assign peripheral_clock_override   = rif.flags[CLGO_BIT_PERIPH];
  assign irq_ctrl_clock_override     = rif.flags[CLGO_BIT_IRQ];
  assign power_policy_clock_override = rif.flags[CLGO_BIT_POWER];
  // in multi complex mode bit 0 is masked and stays low
  assign processor_clock_override    = rif.flags[CLGO_BIT_PROC];
  assign per_complex_clock_override  = rif.flags[CLGO_BIT_CPLX_HI:CLGO_BIT_CPLX_LO];

  // checks on the behaviour above
  // all run on the bus clock and are muted while reset is low, so the
  // edges around a release see only reset values
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // status read returns the flags held at the capture edge
  a_status_read_data: assert property (
    (psel && penable && !pready && !pwrite && decode(paddr) == CLGO_REG_STATUS)
    |=> (pready && prdata == {CLGO_RSVD_ZERO, $past(rif.flags)})
  ) else $error("status read does not return the flag state");

  // a forced peripheral clock reads back as one on the next status read
  // that follows the write after one idle bus cycle
  a_forced_reads_one: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET && wr_bits[CLGO_BIT_PERIPH])
    ##1 !psel
    ##1 (psel && !penable && !pwrite && decode(paddr) == CLGO_REG_STATUS)
    ##1 (psel && penable)
    |=> prdata[CLGO_BIT_PERIPH]
  ) else $error("forced clock does not read as disabled");

  // every live one written to set ends up high
  a_set_raises_flags: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET)
    |=> ((rif.flags & $past(wr_bits)) == $past(wr_bits))
  ) else $error("set write did not raise its flags");

  // every one written to clear ends up low
  a_clear_drops_flags: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_CLEAR)
    |=> ((rif.flags & $past(wr_bits)) == CLGO_FLAG_RESET)
  ) else $error("clear write did not drop its flags");

  // zeros in the written word leave their flags alone
  a_zero_bits_inert: assert property (
    (rif.acc_wr && (acc_reg == CLGO_REG_SET || acc_reg == CLGO_REG_CLEAR))
    |=> (((rif.flags ^ $past(rif.flags)) & ~$past(wr_bits)) == CLGO_FLAG_RESET)
  ) else $error("zero bit in a set or clear write changed a flag");

  // a clear drops the power and irq overrides at their status bit positions
  a_same_bit_map: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_CLEAR)
    |=> (power_policy_clock_override ==
         ($past(power_policy_clock_override) && !$past(wr_bits[CLGO_BIT_POWER])))
     && (irq_ctrl_clock_override ==
         ($past(irq_ctrl_clock_override) && !$past(wr_bits[CLGO_BIT_IRQ])))
  ) else $error("clear register does not follow the status bit map");

  // bits without gating never become one
  a_reserved_stay_low: assert property (
    (rif.flags & ~VALID_MASK) == CLGO_FLAG_RESET
  ) else $error("a reserved override bit is set");

  // the three cluster outputs follow the documented positions after a set
  a_cluster_bit_map: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET)
    |=> (peripheral_clock_override ==
         ($past(peripheral_clock_override) || $past(wr_bits[CLGO_BIT_PERIPH])))
     && (irq_ctrl_clock_override ==
         ($past(irq_ctrl_clock_override) || $past(wr_bits[CLGO_BIT_IRQ])))
     && (power_policy_clock_override ==
         ($past(power_policy_clock_override) || $past(wr_bits[CLGO_BIT_POWER])))
  ) else $error("cluster override outputs do not match the bit map");

  // first complex bit drives the first complex override
  a_complex_bit_map: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET && wr_bits[CLGO_BIT_CPLX_LO])
    |=> (multi_complex_mode && per_complex_clock_override[0])
  ) else $error("complex override bit did not follow its write");

  // reserved high bits of any answer read zero
  a_reserved_read_zero: assert property (
    pready |-> (prdata[CLGO_DW-1:CLGO_NUM_FLAGS] == CLGO_RSVD_ZERO)
  ) else $error("reserved read bits are not zero");

  // flags move only on a completed set or clear write
  a_flags_hold_idle: assert property (
    !(rif.acc_wr && (acc_reg == CLGO_REG_SET || acc_reg == CLGO_REG_CLEAR))
    |=> $stable(rif.flags)
  ) else $error("a flag changed without a set or clear write");

  // the bus answers after exactly one wait cycle, for one cycle
  a_one_wait_state: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready
  ) else $error("apb answer is not one wait cycle");

  // unmapped addresses answer with an error
  a_unmapped_error: assert property (
    (psel && penable && !pready && decode(paddr) == CLGO_REG_NONE) |=> pslverr
  ) else $error("unmapped access did not report an error");

  // mapped addresses never answer with an error
  a_mapped_no_error: assert property (
    (psel && penable && !pready && decode(paddr) != CLGO_REG_NONE) |=> !pslverr
  ) else $error("mapped access reported an error");

  // between answers the read bus and the error line rest at zero,
  // so a stale word can never be mistaken for a fresh one
  a_answer_idle_zero: assert property (
    !pready |-> (prdata == CLGO_RDATA_RESET && !pslverr)
  ) else $error("read data or error shown outside an answer");

  // the answer only comes while the master still holds its access
  a_ready_needs_access: assert property (
    pready |-> (psel && penable)
  ) else $error("ready raised without a pending access");

  // strobes reach the flags only on the completing edge of a write
  a_strobe_needs_ready: assert property (
    (rif.set_bits != CLGO_FLAG_RESET || rif.clr_bits != CLGO_FLAG_RESET)
    |-> (psel && penable && pready && pwrite)
  ) else $error("set or clear strobe outside a completing write");

  // the write only registers read zero
  a_wo_read_zero: assert property (
    (psel && penable && !pready && !pwrite
     && (decode(paddr) == CLGO_REG_SET || decode(paddr) == CLGO_REG_CLEAR))
    |=> (prdata == CLGO_RDATA_RESET)
  ) else $error("a write only register returned data");

  // status is read only: a write to it leaves every flag alone
  a_status_write_inert: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_STATUS) |=> $stable(rif.flags)
  ) else $error("a status write changed a flag");

  // status bits sit in the same order as the override pins
  a_status_pin_order: assert property (
    (psel && penable && !pready && !pwrite && decode(paddr) == CLGO_REG_STATUS)
    |=> (prdata[CLGO_BIT_CPLX_HI:CLGO_BIT_PROC] ==
         {$past(per_complex_clock_override), $past(peripheral_clock_override),
          $past(irq_ctrl_clock_override), $past(power_policy_clock_override),
          $past(processor_clock_override)})
  ) else $error("status bits do not follow the override outputs");

  // in direct mode bit 0 drives the processor clock override
  a_proc_set_direct: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET && wr_bits[CLGO_BIT_PROC])
    |=> processor_clock_override
  ) else $error("processor override did not follow its set bit");

  // in multi complex mode bit 0 is reserved and its pin stays low
  a_proc_low_multi: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET && rif.acc_wdata[CLGO_BIT_PROC]
     && multi_complex_mode) |=> !processor_clock_override
  ) else $error("processor override rose in multi complex mode");

  // clear uses the status map for the peripheral clock too
  a_periph_clear_map: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_CLEAR && wr_bits[CLGO_BIT_PERIPH])
    |=> !peripheral_clock_override
  ) else $error("peripheral override did not follow its clear bit");

  // and for the processor clock
  a_proc_clear_map: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_CLEAR && wr_bits[CLGO_BIT_PROC])
    |=> !processor_clock_override
  ) else $error("processor override did not follow its clear bit");

  // first complex bit of the clear register drops the first complex pin
  a_complex_clear: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_CLEAR && wr_bits[CLGO_BIT_CPLX_LO])
    |=> !per_complex_clock_override[0]
  ) else $error("complex override did not follow its clear bit");

  // complexes past the implemented count never get an override
  a_unused_cplx_low: assert property (
    (rif.acc_wr && acc_reg == CLGO_REG_SET)
    |=> (per_complex_clock_override ==
         (per_complex_clock_override & VALID_MASK[CLGO_BIT_CPLX_HI:CLGO_BIT_CPLX_LO]))
  ) else $error("an unused complex override is set");

  // leaving reset every clock is gated again, whatever was forced before
  a_reset_clears_flags: assert property (
    $rose(presetn) |-> (rif.flags == CLGO_FLAG_RESET)
  ) else $error("flags not at reset value after reset");

endmodule

// file: tb_top.sv
`timescale 1ns/100ps

// self-checking bench: a direct-mode and a multi-complex instance share one apb master
module tb_top;
  import clgo_pkg::*;

  // implemented bits: direct mode all four cluster bits; five complexes, irq clock ungated
  localparam logic [31:0] MASK0 = 32'h0000_000f;
  localparam logic [31:0] MASK1 = 32'h0000_01fa;

  logic                     pclk, presetn, psel, penable, pwrite;  // bus inputs
  logic [CLGO_AW-1:0]       paddr;                                 // byte address
  logic [CLGO_DW-1:0]       pwdata, prdata0, prdata1, rd0, rd1;    // data, captured reads
  logic                     pready0, pready1, pslverr0, pslverr1;  // answers
  logic                     e0, e1;                                // captured errors
  logic                     per0, irq0, pow0, proc0;               // direct overrides
  logic                     per1, irq1, pow1, proc1;               // multi overrides
  logic [CLGO_MAX_CPLX-1:0] cplx0, cplx1;                          // complex overrides
  logic [11:0]              ov0, ov1;                              // overrides in status order
  int                       miscompares, cmp_count, cycles;        // counters

  assign ov0 = {cplx0, per0, irq0, pow0, proc0};
  assign ov1 = {cplx1, per1, irq1, pow1, proc1};

  clgo_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready0), .prdata(prdata0),
    .pslverr(pslverr0), .peripheral_clock_override(per0), .irq_ctrl_clock_override(irq0),
    .power_policy_clock_override(pow0), .processor_clock_override(proc0),
    .per_complex_clock_override(cplx0));

  clgo_top #(.multi_complex_mode(1'b1), .complex_count(5), .cluster_gating_impl(4'hb)) dut_mc (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready1), .prdata(prdata1),
    .pslverr(pslverr1), .peripheral_clock_override(per1), .irq_ctrl_clock_override(irq1),
    .power_policy_clock_override(pow1), .processor_clock_override(proc1),
    .per_complex_clock_override(cplx1));

  // 10 mhz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // hang guard, far above the some 145 transfers, about 600 cycles, of the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      finish_test();
    end
  end

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready as long as it takes, only the hang guard ends it
  task automatic apb(input logic wr, input logic [CLGO_AW-1:0] a, input logic [CLGO_DW-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready0 !== 1'b1);
    rd0 = prdata0;
    rd1 = prdata1;
    e0 = pslverr0;
    e1 = pslverr1;
    chk("pready pair", {30'h0, pready1, pready0}, 32'h3);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // status read plus override pins of both instances
  task automatic expect_status(input logic [31:0] x0, input logic [31:0] x1);
    apb(1'b0, CLGO_OFS_STATUS, 32'h0);
    chk("status direct", rd0, x0);
    chk("status multi", rd1, x1);
    chk("overrides direct", {20'h0_0000, ov0}, x0);
    chk("overrides multi", {20'h0_0000, ov1}, x1);
  endtask

  // reset state, write-only registers read as zero
  task automatic t_reset_values();
    expect_status(32'h0, 32'h0);
    apb(1'b0, CLGO_OFS_SET, 32'h0);
    chk("set readback", rd0 | rd1, 32'h0);
    apb(1'b0, CLGO_OFS_CLEAR, 32'h0);
    chk("clear readback", rd0 | rd1, 32'h0);
  endtask

  // all ones, then zero writes that must change nothing
  task automatic t_set_all();
    apb(1'b1, CLGO_OFS_SET, 32'hffff_ffff);
    chk("set error", {30'h0, e1, e0}, 32'h0);
    expect_status(MASK0, MASK1);
    apb(1'b1, CLGO_OFS_SET, 32'h0);
    apb(1'b1, CLGO_OFS_CLEAR, 32'h0);
    expect_status(MASK0, MASK1);
    apb(1'b1, CLGO_OFS_CLEAR, 32'hffff_ffff);
    expect_status(32'h0, 32'h0);
  endtask

  // one bit at a time through set then clear, building up and then draining the map lane by lane
  task automatic t_walk();
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, CLGO_OFS_SET, 32'h1 << i);
      s = s | (32'h1 << i);
      expect_status(s & MASK0, s & MASK1);
    end
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, CLGO_OFS_CLEAR, 32'h1 << i);
      s = s & ~(32'h1 << i);
      expect_status(s & MASK0, s & MASK1);
    end
  endtask

  // read-only status, unmapped and misaligned places leave the flags alone
  task automatic t_refused();
    apb(1'b1, CLGO_OFS_SET, 32'h0000_0012);
    apb(1'b1, CLGO_OFS_STATUS, 32'hffff_ffff);
    chk("status write error", {30'h0, e1, e0}, 32'h0);
    apb(1'b1, 12'ha0c, 32'hffff_ffff);
    chk("unmapped error", {30'h0, e1, e0}, 32'h3);
    apb(1'b1, 12'ha05, 32'hffff_ffff);
    chk("misaligned error", {30'h0, e1, e0}, 32'h3);
    apb(1'b0, 12'ha02, 32'h0);
    chk("misaligned read", rd0 | rd1, 32'h0);
    expect_status(32'h0000_0012 & MASK0, 32'h0000_0012 & MASK1);
  endtask

  // reset in mid-run drops every flag
  task automatic t_mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("overrides in reset", {8'h00, ov1, ov0}, 32'h0);
    presetn <= 1'b1;
    expect_status(32'h0, 32'h0);
  endtask

  // main sequence
  initial begin
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_set_all();
    t_walk();
    t_refused();
    t_mid_reset();
    finish_test();
  end
endmodule
